// File: rtl/spsec_dev.sv
// spsec_dev: flash device end for security pages and status reads
`timescale 1ns/100ps
module spsec_dev
    import spsec_pkg::*;
#(
    parameter int ERASE_CNT = ERASE_CYCLES,
    parameter int PROG_CNT  = PROG_CYCLES
) (
    input  wire logic       sys_clk_i,
    input  wire logic       rst_i,
    input  wire logic [2:0] lock_set_i,      // one-time lock requests, page 3..1
    output logic [2:0]      security_page_lock_bits_o,
    output logic            ready_busy_flag_o,
    output logic            write_enable_latch_o,
    spsec_if.dev            link
);
    import spsec_pkg::*;
    typedef enum logic [1:0] {D_IDLE, D_ERASE, D_PROG} spsec_op_t;
    spsec_op_t   op_reg;
    logic [7:0]  mem [3*BUF_DEPTH];
    logic [7:0]  pbuf [BUF_DEPTH];
    logic [7:0]  sh_reg;
    logic [2:0]  bit_reg;
    logic [5:0]  byte_reg;       // bytes received, saturating
    logic [7:0]  opc_reg;
    logic [23:0] addr_reg;
    logic [9:0]  rptr_reg;
    logic [7:0]  out_reg;
    logic        drive_reg;
    logic        cs_q_reg;
    logic        wel_reg;
    logic [2:0]  lock_reg;
    logic [31:0] tmr_reg;
    logic [1:0]  tpage_reg;
    logic [7:0]  tbase_reg;
    logic [8:0]  pcnt_reg;
    logic [8:0]  wcnt_reg;
    logic        busy;
    logic [7:0]  rx;
    logic [7:0]  stat1;
    logic [7:0]  stat2;
    logic        sel;
    logic        fin;
    logic [7:0]  f_data;
    logic        f_valid;
    logic        f_ready;

    // page index 0..2 from address, or 3 when not a security page
    function automatic logic [1:0] page_of(input logic [23:0] a);
        if (a[23:16] == SP_TOP_BYTE && a[15:8] >= SP_PAGE_FIRST && a[15:8] <= SP_PAGE_LAST)
            page_of = 2'(a[15:8] - SP_PAGE_FIRST);
        else
            page_of = 2'd3;
    endfunction : page_of

    assign busy  = (op_reg != D_IDLE);
    assign stat1 = {6'h00, wel_reg, busy};
    assign stat2 = {2'h0, lock_reg, 3'h0};
    assign sel   = !link.cs_n && link.sck;
    assign rx    = {sh_reg[6:0], link.mosi};
    assign fin   = !cs_q_reg && link.cs_n;                       // release edge
    assign ready_busy_flag_o         = busy;
    assign write_enable_latch_o      = wel_reg;
    assign security_page_lock_bits_o = lock_reg;
    // output floats whenever select is released
    assign link.miso_o    = out_reg[7];
    assign link.miso_oe_n = !(drive_reg && !link.cs_n);

    // bit and byte capture
    always_ff @(posedge sys_clk_i) begin
        if (rst_i || link.cs_n) begin
            bit_reg  <= '0;
            byte_reg <= '0;
            sh_reg   <= '0;
            opc_reg  <= '0;
            addr_reg <= '0;
        end else if (sel) begin
            sh_reg  <= rx;
            bit_reg <= bit_reg + 3'd1;
            if (bit_reg == 3'd7) begin
                if (byte_reg != 6'h3f) byte_reg <= byte_reg + 6'd1;
                if (byte_reg == 6'd0) opc_reg <= rx;
                if (byte_reg >= 6'd1 && byte_reg <= 6'd3) addr_reg <= {addr_reg[15:0], rx};
            end
        end
    end

    // program data fifo decouples shifting from buffer fill
    spsec_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
        .sys_clk_i   (sys_clk_i),
        .rst_i       (rst_i),
        .in_data_i   (rx),
        .in_valid_i  (sel && bit_reg == 3'd7 && byte_reg >= 6'd4 && opc_reg == OP_SP_PROG
                      && !busy),
        .in_ready_o  (),
        .out_data_o  (f_data),
        .out_valid_o (f_valid),
        .out_ready_i (f_ready)
    );
    // buffer fills one byte per clock, faster than bytes arrive, so it never overflows
    assign f_ready = 1'b1;

    // shared page buffer, overwritten by each program command sent while not busy
    always_ff @(posedge sys_clk_i) begin
        if (f_valid && f_ready && wcnt_reg != 9'(BUF_DEPTH)) begin
            pbuf[8'(wcnt_reg)] <= f_data;
        end
    end
    always_ff @(posedge sys_clk_i) begin
        // only a new program opcode restarts the fill; status polls must not
        if (rst_i || (sel && bit_reg == 3'd7 && byte_reg == 6'd0 && rx == OP_SP_PROG && !busy))
            wcnt_reg <= '0;
        else if (f_valid && wcnt_reg != 9'(BUF_DEPTH)) wcnt_reg <= wcnt_reg + 9'd1;
    end

    // serial output: status repeats, security data streams
    always_ff @(posedge sys_clk_i) begin
        if (rst_i || link.cs_n) begin
            drive_reg <= 1'b0;
            out_reg   <= '0;
            rptr_reg  <= '0;
        end else if (sel) begin
            out_reg <= {out_reg[6:0], 1'b0};
            if (bit_reg == 3'd7) begin
                if (byte_reg == 6'd0 && (rx == OP_STAT1 || rx == OP_STAT2)) begin
                    drive_reg <= 1'b1;
                    out_reg   <= (rx == OP_STAT1) ? stat1 : stat2;
                end else if (byte_reg >= 6'd1 && (opc_reg == OP_STAT1 || opc_reg == OP_STAT2)) begin
                    out_reg <= (opc_reg == OP_STAT1) ? stat1 : stat2;  // fresh copy
                end else if (opc_reg == OP_SP_READ && byte_reg == 6'd3) begin
                    rptr_reg <= {addr_reg[1:0], rx};  // middle byte low bits
                end else if (opc_reg == OP_SP_READ && byte_reg >= 6'd4) begin
                    drive_reg <= 1'b1;
                    out_reg   <= (page_of(addr_reg) == 2'd3) ? 8'hff
                                 : mem[{page_of(addr_reg), rptr_reg[7:0]}];
                    rptr_reg  <= (rptr_reg == SP_ADDR_LAST) ? SP_ADDR_FIRST
                                 : rptr_reg + 10'd1;
                end
            end
        end
    end

    // edge of select for release detection
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) cs_q_reg <= 1'b1;
        else       cs_q_reg <= link.cs_n;
    end

    // write enable latch and self-timed operation sequencer
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            wel_reg   <= 1'b0;
            op_reg    <= D_IDLE;
            tmr_reg   <= '0;
            tpage_reg <= '0;
            pcnt_reg  <= '0;
            tbase_reg <= '0;
        end else begin
            unique case (op_reg)
                D_IDLE: begin
                    if (fin && bit_reg == 3'd0 && byte_reg == 6'd1) begin
                        if (opc_reg == OP_WREN)  wel_reg <= 1'b1;
                        if (opc_reg == OP_WRDIS) wel_reg <= 1'b0;
                    end
                    if (fin && opc_reg == OP_SP_ERASE && byte_reg != 6'd0) begin
                        // exactly opcode plus three address bytes, on a byte edge
                        if (bit_reg == 3'd0 && byte_reg == 6'd4 && wel_reg
                            && page_of(addr_reg) != 2'd3
                            && !lock_reg[page_of(addr_reg)]) begin
                            op_reg    <= D_ERASE;
                            tpage_reg <= page_of(addr_reg);
                            tmr_reg   <= '0;
                        end else begin
                            wel_reg <= 1'b0;
                        end
                    end
                    if (fin && opc_reg == OP_SP_PROG && byte_reg != 6'd0) begin
                        if (bit_reg == 3'd0 && byte_reg >= 6'd5 && wel_reg
                            && page_of(addr_reg) != 2'd3
                            && !lock_reg[page_of(addr_reg)]) begin
                            op_reg    <= D_PROG;
                            tpage_reg <= page_of(addr_reg);
                            tbase_reg <= addr_reg[7:0];
                            tmr_reg   <= '0;
                            pcnt_reg  <= '0;
                        end else begin
                            wel_reg <= 1'b0;
                        end
                    end
                end
                D_ERASE: begin
                    tmr_reg <= tmr_reg + 32'd1;
                    if (tmr_reg == 32'(ERASE_CNT - 1)) begin
                        op_reg  <= D_IDLE;
                        wel_reg <= 1'b0;
                    end
                end
                D_PROG: begin
                    tmr_reg <= tmr_reg + 32'd1;
                    if (pcnt_reg != 9'(BUF_DEPTH)) pcnt_reg <= pcnt_reg + 9'd1;
                    if (tmr_reg == 32'(PROG_CNT - 1)) begin
                        op_reg  <= D_IDLE;
                        wel_reg <= 1'b0;
                    end
                end
                default: op_reg <= D_IDLE;
            endcase
        end
    end

    // array: erase sweeps page to ff, program ands buffer bytes in
    always_ff @(posedge sys_clk_i) begin
        if (op_reg == D_ERASE && tmr_reg < 32'(BUF_DEPTH)) begin
            mem[{tpage_reg, tmr_reg[7:0]}] <= 8'hff;
        end else if (op_reg == D_PROG && pcnt_reg < wcnt_reg) begin
            mem[{tpage_reg, 8'(tbase_reg + pcnt_reg[7:0])}] <=
                mem[{tpage_reg, 8'(tbase_reg + pcnt_reg[7:0])}] & pbuf[pcnt_reg[7:0]];
        end
    end

    // one-time lock bits: set only, cleared only by reset to LOCK_RESET
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) lock_reg <= LOCK_RESET;
        else       lock_reg <= lock_reg | lock_set_i;
    end
endmodule : spsec_dev

// File: rtl/spsec_fifo.sv
// spsec_fifo: parameterised valid/ready fifo
`timescale 1ns/100ps
module spsec_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input  wire logic             sys_clk_i,
    input  wire logic             rst_i,
    input  wire logic [WIDTH-1:0] in_data_i,
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    output logic [WIDTH-1:0]      out_data_o,
    output logic                  out_valid_o,
    input  wire logic             out_ready_i
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr_reg;
    logic [AW-1:0]    rd_ptr_reg;
    logic [AW:0]      count_reg;
    logic             push;
    logic             pop;

    // honest flags from the occupancy count
    assign in_ready_o  = (count_reg != (AW+1)'(DEPTH));
    assign out_valid_o = (count_reg != '0);
    assign out_data_o  = mem[rd_ptr_reg];
    assign push        = in_valid_i && in_ready_o;
    assign pop         = out_valid_o && out_ready_i;

    // storage write
    always_ff @(posedge sys_clk_i) begin
        if (push) begin
            mem[wr_ptr_reg] <= in_data_i;
        end
    end

    // pointers and count
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg  <= '0;
        end else begin
            if (push) wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH-1)) ? '0 : wr_ptr_reg + 1'b1;
            if (pop)  rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH-1)) ? '0 : rd_ptr_reg + 1'b1;
            count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule : spsec_fifo

// File: rtl/spsec_host.sv
// spsec_host: spi host controller end, one command per request
`timescale 1ns/100ps
module spsec_host
    import spsec_pkg::*;
(
    input  wire logic        sys_clk_i,
    input  wire logic        rst_i,
    input  wire logic        cmd_valid_i,  // start a command
    output logic             cmd_ready_o,  // idle, command accepted
    input  wire logic [7:0]  cmd_op_i,     // opcode
    input  wire logic [23:0] cmd_addr_i,   // address, used when has_addr
    input  wire logic        cmd_has_addr_i,
    input  wire logic        cmd_dummy_i,  // one dummy byte after address
    input  wire logic [8:0]  cmd_len_i,    // data bytes written or read
    input  wire logic        cmd_rd_i,     // data phase reads
    input  wire logic [7:0]  wr_data_i,    // program data stream
    input  wire logic        wr_valid_i,
    output logic             wr_ready_o,
    output logic [7:0]       rd_data_o,    // read data stream
    output logic             rd_valid_o,
    spsec_if.host            link
);
    import spsec_pkg::*;
    typedef enum logic [1:0] {H_IDLE, H_SHIFT, H_DONE} spsec_hst_t;
    spsec_hst_t state_reg;
    logic [7:0]  sh_reg;
    logic [2:0]  bit_reg;
    logic [2:0]  phase_reg;   // 0 op,1..3 addr,4 dummy,5 data
    logic [8:0]  left_reg;
    logic [1:0]  ab_reg;
    logic [23:0] addr_reg;
    logic        rd_reg;
    logic        dummy_reg;
    logic        hasaddr_reg;
    logic        load_data;

    assign cmd_ready_o = (state_reg == H_IDLE);
    // no strobe while stalled for program data, else the device takes a stale bit
    assign link.sck    = (state_reg == H_SHIFT) && !(load_data && !wr_valid_i);
    assign link.mosi   = sh_reg[7];
    // next byte is a program byte; stall until the source has one
    assign load_data   = (bit_reg == 3'd7) && (phase_reg == 3'd5 || (phase_reg != 3'd5 &&
                         !(hasaddr_reg && phase_reg < 3'd3) && !(dummy_reg && phase_reg < 3'd4)))
                         && !rd_reg && left_reg != '0;
    assign wr_ready_o  = (state_reg == H_SHIFT) && load_data;

    // byte-serial command engine; cs released right after the last bit
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            state_reg <= H_IDLE;
            link.cs_n <= 1'b1;
            sh_reg    <= '0;
            bit_reg   <= '0;
            phase_reg <= '0;
            left_reg  <= '0;
            ab_reg    <= '0;
            addr_reg  <= '0;
            rd_reg    <= 1'b0;
            dummy_reg <= 1'b0;
            hasaddr_reg <= 1'b0;
            rd_data_o <= '0;
            rd_valid_o <= 1'b0;
        end else begin
            rd_valid_o <= 1'b0;
            unique case (state_reg)
                H_IDLE: begin
                    if (cmd_valid_i) begin  // opcode first
                        state_reg   <= H_SHIFT;
                        link.cs_n   <= 1'b0;
                        sh_reg      <= cmd_op_i;
                        bit_reg     <= '0;
                        phase_reg   <= '0;
                        ab_reg      <= '0;
                        addr_reg    <= cmd_addr_i;
                        left_reg    <= cmd_len_i;
                        rd_reg      <= cmd_rd_i;
                        dummy_reg   <= cmd_dummy_i;
                        hasaddr_reg <= cmd_has_addr_i;
                    end
                end
                H_SHIFT: begin
                    if (load_data && !wr_valid_i) begin
                        state_reg <= H_SHIFT;  // hold sck low path via stall below
                    end
                    if (!(load_data && !wr_valid_i)) begin
                        sh_reg  <= {sh_reg[6:0], link.miso};
                        bit_reg <= bit_reg + 3'd1;
                    end
                    if (bit_reg == 3'd7 && !(load_data && !wr_valid_i)) begin
                        if (rd_reg && phase_reg == 3'd5) begin
                            rd_data_o  <= {sh_reg[6:0], link.miso};
                            rd_valid_o <= 1'b1;
                        end
                        if (hasaddr_reg && ab_reg != 2'd3) begin  // three address bytes
                            phase_reg <= 3'd1 + 3'(ab_reg);
                            ab_reg    <= ab_reg + 2'd1;
                            sh_reg    <= addr_reg[23:16];
                            addr_reg  <= {addr_reg[15:0], 8'h00};
                        end else if (dummy_reg && phase_reg != 3'd4 && phase_reg != 3'd5) begin
                            phase_reg <= 3'd4;            // dummy byte
                            sh_reg    <= 8'h00;
                        end else if (left_reg != '0) begin
                            phase_reg <= 3'd5;            // data after address
                            left_reg  <= left_reg - 9'd1;
                            sh_reg    <= rd_reg ? 8'h00 : wr_data_i;
                        end else begin
                            state_reg <= H_DONE;
                            link.cs_n <= 1'b1;
                        end
                    end
                end
                H_DONE: state_reg <= H_IDLE;
                default: state_reg <= H_IDLE;
            endcase
        end
    end
endmodule : spsec_host

// File: rtl/spsec_if.sv
// spsec_if: spi link between host controller and flash device
`timescale 1ns/100ps
interface spsec_if;
    logic cs_n;      // chip select, active low
    logic sck;       // serial clock, sampled as data by the device
    logic mosi;      // host to device
    logic miso_o;    // device drive value
    logic miso_oe_n; // device drive enable, low while driving
    logic miso;      // resolved line seen by host

    // undriven line reads high, standing in for high impedance
    assign miso = miso_oe_n ? 1'b1 : miso_o;

    modport dev  (input cs_n, input sck, input mosi, output miso_o, output miso_oe_n);
    modport host (output cs_n, output sck, output mosi, input miso);
endinterface : spsec_if

// File: rtl/spsec_pkg.sv
// spsec_pkg: shared constants for the security page command link
package spsec_pkg;
    // ------------------------------------------------------------
    // opcodes
    // ------------------------------------------------------------
    localparam logic [7:0] OP_WREN     = 8'h06;
    localparam logic [7:0] OP_WRDIS    = 8'h04;
    localparam logic [7:0] OP_SP_ERASE = 8'h44;
    localparam logic [7:0] OP_SP_PROG  = 8'h42;
    localparam logic [7:0] OP_SP_READ  = 8'h48;
    localparam logic [7:0] OP_STAT1    = 8'h05;
    localparam logic [7:0] OP_STAT2    = 8'h35;
    // ------------------------------------------------------------
    // addressing and status layout
    // ------------------------------------------------------------
    localparam logic [7:0] SP_TOP_BYTE   = 8'h00;
    localparam logic [7:0] SP_PAGE_FIRST = 8'h01;
    localparam logic [7:0] SP_PAGE_LAST  = 8'h03;
    localparam logic [9:0] SP_ADDR_LAST  = 10'h3ff;
    localparam logic [9:0] SP_ADDR_FIRST = 10'h000;
    localparam int         ST1_BUSY_BIT  = 0;
    localparam int         ST1_WEL_BIT   = 1;
    localparam int         ST2_LB1_BIT   = 3;
    localparam logic [2:0] LOCK_RESET    = 3'h0;
    // ------------------------------------------------------------
    // timing: self-timed operations in microseconds and clock cycles, plus buffer and fifo depths
    // ------------------------------------------------------------
    localparam int CLK_MHZ        = 100;
    localparam int ERASE_TIME_US  = 100;
    localparam int PROG_TIME_US   = 70;
    localparam int ERASE_CYCLES   = ERASE_TIME_US * CLK_MHZ;
    localparam int PROG_CYCLES    = PROG_TIME_US * CLK_MHZ;
    localparam int BUF_DEPTH      = 256;
    localparam int FIFO_DEPTH     = 8;
endpackage : spsec_pkg

// File: testbench/spsec_props.sv
// spsec_props: assertions on the spi link and the device status flags
`timescale 1ns/100ps
module spsec_props #(
    parameter int ERASE_CNT = 300
) (
    input wire logic       sys_clk_i,
    input wire logic       rst_i,
    input wire logic       cs_n,
    input wire logic       sck,
    input wire logic       miso_oe_n,
    input wire logic       ready_busy_flag_o,
    input wire logic       write_enable_latch_o,
    input wire logic [2:0] security_page_lock_bits_o
);
    int busy_cnt;
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (rst_i);
    // ------------------------------------------------------------
    // busy length counter
    // ------------------------------------------------------------
    // a flag stuck high would hang every poll loop, so bound it here
    always_ff @(posedge sys_clk_i) begin
        if (rst_i || !ready_busy_flag_o) begin
            busy_cnt <= 0;
        end else begin
            busy_cnt <= busy_cnt + 1;
        end
    end
    release_float_a: assert property ($rose(cs_n) |=> miso_oe_n)
        else $error("output driven after release");
    idle_float_a: assert property (cs_n && $past(cs_n) |-> miso_oe_n)
        else $error("output driven while deselected");
    sck_framed_a: assert property (sck |-> !cs_n)
        else $error("bit strobe outside a frame");
    busy_start_a: assert property ($rose(ready_busy_flag_o) |->
        cs_n && ($past(write_enable_latch_o) || $past(write_enable_latch_o, 2)))
        else $error("busy without latch or before release");
    busy_hold_a: assert property ($rose(ready_busy_flag_o) |-> ready_busy_flag_o[*8])
        else $error("busy flag dropped early");
    busy_bound_a: assert property (busy_cnt <= ERASE_CNT + 4)
        else $error("busy flag never cleared");
    latch_clear_a: assert property ($fell(ready_busy_flag_o) |-> !write_enable_latch_o)
        else $error("latch still set after operation");
    lock_sticky_a: assert property (!$past(rst_i) |->
        (security_page_lock_bits_o & $past(security_page_lock_bits_o))
        == $past(security_page_lock_bits_o))
        else $error("lock bit cleared");
endmodule : spsec_props

// File: testbench/tb_top.sv
// tb_top: self-checking bench for the security page link
`timescale 1ns/100ps
module tb_top;
    import spsec_pkg::*;
    logic        sys_clk = 1'b0;
    logic        rst_i   = 1'b1;
    logic        cmd_valid = 1'b0;
    logic        cmd_ready;
    logic [7:0]  cmd_op = 8'h00;
    logic [23:0] cmd_addr = 24'h000000;
    logic        cmd_has_addr = 1'b0;
    logic        cmd_dummy = 1'b0;
    logic [8:0]  cmd_len = 9'h000;
    logic        cmd_rd = 1'b0;
    logic [7:0]  wr_data = 8'h00;
    logic        wr_ready, rd_valid, busy, write_enable_latch;
    logic [7:0]  rd_data, st;
    logic [2:0]  lock_set = 3'h0;
    logic [2:0]  locks;
    logic [7:0]  rq[$];
    int          wr_left = 0;
    int          bad_count = 0;
    int          compares = 0;
    spsec_if lnk ();
    spsec_host spsec_host_i (.sys_clk_i(sys_clk), .rst_i(rst_i), .cmd_valid_i(cmd_valid),
        .cmd_ready_o(cmd_ready), .cmd_op_i(cmd_op), .cmd_addr_i(cmd_addr),
        .cmd_has_addr_i(cmd_has_addr), .cmd_dummy_i(cmd_dummy), .cmd_len_i(cmd_len),
        .cmd_rd_i(cmd_rd), .wr_data_i(wr_data), .wr_valid_i(wr_left > 0),
        .wr_ready_o(wr_ready), .rd_data_o(rd_data), .rd_valid_o(rd_valid), .link(lnk));
    // short self-timed counts keep the run brief; both stay above 256
    spsec_dev #(.ERASE_CNT(300), .PROG_CNT(280)) spsec_dev_i (.sys_clk_i(sys_clk),
        .rst_i(rst_i), .lock_set_i(lock_set), .security_page_lock_bits_o(locks),
        .ready_busy_flag_o(busy), .write_enable_latch_o(write_enable_latch), .link(lnk));
    spsec_props #(.ERASE_CNT(300)) spsec_props_i (.sys_clk_i(sys_clk), .rst_i(rst_i),
        .cs_n(lnk.cs_n), .sck(lnk.sck), .miso_oe_n(lnk.miso_oe_n), .ready_busy_flag_o(busy),
        .write_enable_latch_o(write_enable_latch), .security_page_lock_bits_o(locks));
    // ------------------------------------------------------------
    // clock, read capture and program data source
    // ------------------------------------------------------------
    always #5 sys_clk = ~sys_clk;
    always @(posedge sys_clk) begin
        if (rd_valid === 1'b1) rq.push_back(rd_data);
        if (wr_ready === 1'b1 && wr_left > 0) begin
            wr_data <= wr_data + 8'h01;
            wr_left <= wr_left - 1;
        end
    end
    task automatic test_done;
        $display("mismatches %0d compares %0d", bad_count, compares);
        if (bad_count == 0 && compares > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : test_done
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        compares++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    // bounded wait for the host to go idle; a hang ends the run
    task automatic wait_idle;
        int k;
        k = 0;
        while (cmd_ready !== 1'b1 && k < 6000) begin
            @(posedge sys_clk);
            #1;
            k++;
        end
        if (k >= 6000) begin
            bad_count++;
            test_done();
        end
    endtask : wait_idle
    task automatic cmd(input logic [7:0] op, input logic [23:0] a, input logic ha,
                       input logic dm, input logic [8:0] n, input logic rd);
        wait_idle();
        rq.delete();
        {cmd_op, cmd_addr, cmd_has_addr, cmd_dummy, cmd_len, cmd_rd} = {op, a, ha, dm, n, rd};
        cmd_valid = 1'b1;
        @(posedge sys_clk);
        #1;
        cmd_valid = 1'b0;
        wait_idle();
        // last read byte is flagged a clock after its final bit
        repeat (2) @(posedge sys_clk);
        #1;
        if (rd) chk("read byte count", n[7:0], 8'(rq.size()));
    endtask : cmd
    task automatic wren;
        cmd(OP_WREN, 24'h0, 1'b0, 1'b0, 9'd0, 1'b0);
    endtask : wren
    task automatic stat(input logic [7:0] op, input logic [8:0] n);
        cmd(op, 24'h0, 1'b0, 1'b0, n, 1'b1);
        st = rq[0];
    endtask : stat
    task automatic poll;
        int k;
        k = 0;
        do begin
            stat(OP_STAT1, 9'd1);
            k++;
        end while (st[ST1_BUSY_BIT] !== 1'b0 && k < 100);
        chk("status after operation", 8'h00, st);
        if (st[ST1_BUSY_BIT] !== 1'b0) begin
            bad_count++;
            test_done();
        end
    endtask : poll
    task automatic t_refuse;
        chk("reset flags", 8'h00, {3'h0, locks, write_enable_latch, busy});
        cmd(OP_SP_ERASE, 24'h000300, 1'b1, 1'b0, 9'd0, 1'b0);
        chk("erase without latch", 8'h00, {7'h0, busy});
        wren();
        wr_left = 1;
        cmd(OP_SP_ERASE, 24'h000300, 1'b1, 1'b0, 9'd1, 1'b0);
        stat(OP_STAT1, 9'd1);
        chk("erase with extra byte", 8'h00, st);
    endtask : t_refuse
    task automatic t_erase;
        wren();
        cmd(OP_WRDIS, 24'h0, 1'b0, 1'b0, 9'd0, 1'b0);
        cmd(OP_SP_ERASE, 24'h000300, 1'b1, 1'b0, 9'd0, 1'b0);
        stat(OP_STAT1, 9'd1);
        chk("erase after disable", 8'h00, st);
        wren();
        stat(OP_STAT1, 9'd1);
        chk("latch after enable", 8'h02, st);
        cmd(OP_SP_ERASE, 24'h0003a5, 1'b1, 1'b0, 9'd0, 1'b0);
        stat(OP_STAT1, 9'd3);
        chk("busy first byte", 8'h01, {7'h0, rq[0][0]});
        chk("busy third byte", 8'h01, {7'h0, rq[2][0]});
        poll();
    endtask : t_erase
    task automatic t_prog;
        wren();
        wr_data = 8'h5a;
        wr_left = 2;
        cmd(OP_SP_PROG, 24'h0003fe, 1'b1, 1'b0, 9'd2, 1'b0);
        chk("busy after program", 8'h01, {7'h0, busy});
        poll();
        cmd(OP_SP_READ, 24'h0003fe, 1'b1, 1'b1, 9'd3, 1'b1);
        chk("page byte fe", 8'h5a, rq[0]);
        chk("page byte ff", 8'h5b, rq[1]);
        chk("wrapped byte", 8'hff, rq[2]);
        chk("released enable", 8'h01, {7'h0, lnk.miso_oe_n});
    endtask : t_prog
    task automatic t_lock;
        lock_set = 3'b100;
        @(posedge sys_clk);
        #1;
        lock_set = 3'b000;
        stat(OP_STAT2, 9'd2);
        chk("lock first byte", 8'h20, rq[0] & 8'h38);
        chk("lock second byte", 8'h20, rq[1] & 8'h38);
        wren();
        cmd(OP_SP_ERASE, 24'h000300, 1'b1, 1'b0, 9'd0, 1'b0);
        stat(OP_STAT1, 9'd1);
        chk("erase of locked page", 8'h00, st);
        wren();
        wr_left = 1;
        cmd(OP_SP_PROG, 24'h0003fe, 1'b1, 1'b0, 9'd1, 1'b0);
        stat(OP_STAT1, 9'd1);
        chk("program of locked page", 8'h00, st);
        cmd(OP_SP_READ, 24'h0003fe, 1'b1, 1'b1, 9'd1, 1'b1);
        chk("locked page kept", 8'h5a, rq[0]);
    endtask : t_lock
    initial begin
        repeat (2) @(posedge sys_clk);
        #1;
        rst_i = 1'b0;
        t_refuse();
        t_erase();
        t_prog();
        t_lock();
        test_done();
    end
endmodule : tb_top
